// >>> include/sms_regs.vh
/*
  Constants for the sampled magnetic switch: variant codes, timing figures and
  field thresholds. Assumes field samples in microtesla, signed, and a 100 MHz clock.
*/
`ifndef SMS_REGS_VH
`define SMS_REGS_VH

// Clock
`define SMS_CLK_HZ          100000000

// Variant codes
`define SMS_VAR_FAST_OMNI_PP 2'h0
`define SMS_VAR_SLOW_OMNI_PP 2'h1
`define SMS_VAR_FAST_OMNI_OD 2'h2
`define SMS_VAR_FAST_DUAL_PP 2'h3

// Sampling periods in ms, and power-on time in us
`define SMS_PERIOD_FAST_MS  50
`define SMS_PERIOD_SLOW_MS  200
`define SMS_TON_US          100

// Cycle counts derived from the figures (all exact at 100 MHz, nothing rounds)
`define SMS_PERIOD_FAST_CYC (`SMS_PERIOD_FAST_MS * (`SMS_CLK_HZ / 1000))
`define SMS_PERIOD_SLOW_CYC (`SMS_PERIOD_SLOW_MS * (`SMS_CLK_HZ / 1000))
`define SMS_TON_CYC         (`SMS_TON_US * (`SMS_CLK_HZ / 1000000))

// Thresholds in microtesla (3 mT operate, 1.5 mT release)
`define SMS_OPERATE_UT      3000
`define SMS_RELEASE_UT      1500

`endif

// >>> hw/sms_tick_gen.v
/*
  Sample tick generator: one pulse after the power-on delay, then one pulse per
  sampling period. Assumes a free-running single clock.
*/
module sms_tick_gen #(
  parameter integer CW        = 32,
  parameter integer TON_CYC   = 10000,
  parameter integer PERIOD_CYC = 5000000
) (
  // Clock and reset
  input  wire          clk_i,
  input  wire          rst_b_i,
  // Tick
  output reg           tick_o,
  output reg           first_o
);

  reg [CW-1:0] cnt_ff;
  reg          started_ff;
  wire [CW-1:0] limit = started_ff ? PERIOD_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}
                                   : TON_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};

  // Counter wraps at the active limit and fires a single-cycle tick
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_ff     <= {CW{1'b0}};
      started_ff <= 1'b0;
      tick_o     <= 1'b0;
      first_o    <= 1'b0;
    end else begin
      tick_o  <= 1'b0;
      first_o <= 1'b0;
      if (cnt_ff == limit) begin
        cnt_ff     <= {CW{1'b0}};
        started_ff <= 1'b1;
        tick_o     <= 1'b1;
        first_o    <= ~started_ff;
      end else begin
        cnt_ff <= cnt_ff + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // sms_tick_gen

// >>> hw/sms_hyst_cmp.v
/*
  Hysteresis comparator for one output. Active-low detect state held in a flop
  and changed only on the sample tick. Assumes an unsigned magnitude sample.
*/
module sms_hyst_cmp #(
  parameter integer FW      = 16,
  parameter integer OPERATE = 3000,
  parameter integer RELEASE = 1500
) (
  // Clock and reset
  input  wire          clk_i,
  input  wire          rst_b_i,
  // Sample
  input  wire          tick_i,
  input  wire [FW-1:0] mag_i,
  // State
  output reg           det_b_o
);

  localparam [FW-1:0] OP_T = OPERATE[FW-1:0];
  localparam [FW-1:0] RP_T = RELEASE[FW-1:0];

  // Asserts above operate, releases below release, otherwise holds
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      det_b_o <= 1'b1;
    end else if (tick_i) begin
      if (mag_i > OP_T) begin
        det_b_o <= 1'b0;
      end else if (mag_i < RP_T) begin
        det_b_o <= 1'b1;
      end
    end
  end

endmodule // sms_hyst_cmp

// >>> hw/sms_switch.v
/*
  Sampled magnetic switch top: power-on sample, periodic re-sampling, hysteresis
  against operate and release thresholds, omnipolar or dual-unipolar response,
  push-pull or open-drain output. Assumes field_i is a signed microtesla sample,
  positive for bottom-to-top flux, valid whenever sampled.
*/
//
// Behaviour
// - After reset the first sample is taken one cycle after the power-on delay and the output set one cycle later.
// - Between samples the output is held in a latch while the sensor sleeps.
// - Each sampling period the field is re-sampled and the output changed only if needed.
// - An unchanged field leaves the output steady with no glitch.
// - Sampling rate is a build option: 20 Hz for three variants, 5 Hz for the slow push-pull one.
// - Bottom-to-top flux is positive and top-to-bottom flux negative.
// - Omnipolar variants compare the field magnitude regardless of sign.
// - The dual variant has a north output for negative flux and a south output for positive flux.
// - Near-zero field leaves both dual outputs high, giving three states in all.
// - Push-pull drives both levels; open-drain pulls low or releases.
// - There is one operating mode with no configuration.
// - Output asserts low above the operate threshold and releases below the release threshold.
// - Sampling period is 50 ms at 20 Hz and 200 ms at 5 Hz.
`include "sms_regs.vh"

module sms_switch #(
  parameter [1:0]   VARIANT    = `SMS_VAR_FAST_OMNI_PP,
  parameter integer FW         = 16,
  parameter integer OPERATE    = `SMS_OPERATE_UT,
  parameter integer RELEASE    = `SMS_RELEASE_UT,
  parameter integer TON_CYC    = `SMS_TON_CYC,
  parameter integer PERIOD_CYC = (VARIANT == `SMS_VAR_SLOW_OMNI_PP) ? `SMS_PERIOD_SLOW_CYC
                                                                    : `SMS_PERIOD_FAST_CYC
) (
  // Clock and reset
  input  wire          clk_i,
  input  wire          rst_b_i,
  // Field sample, signed, positive means south above
  input  wire [FW-1:0] field_i,
  // North or omnipolar output pin
  output reg           north_detect_out_o,
  output reg           north_detect_oe_o,
  // South output pin, dual variant only
  output reg           south_detect_out_o,
  output reg           south_detect_oe_o,
  // Status
  output reg           awake_o,
  output reg           valid_o
);

  localparam DUAL = (VARIANT == `SMS_VAR_FAST_DUAL_PP);
  localparam OPEN = (VARIANT == `SMS_VAR_FAST_OMNI_OD);

  // Magnitude without overflow at the most negative code
  function [FW-1:0] sms_abs;
    input [FW-1:0] v;
    begin
      sms_abs = v[FW-1] ? (~v + {{(FW-1){1'b0}}, 1'b1}) : v;
    end
  endfunction

  wire          tick;
  wire          om_det_b;
  wire          n_det_b;
  wire          s_det_b;
  reg  [FW-1:0] om_mag;
  reg  [FW-1:0] n_mag;
  reg  [FW-1:0] s_mag;
  reg           nxt_n_out;
  reg           nxt_s_out;
  reg           tick_d_ff;

  sms_tick_gen #(
    .CW         (32),
    .TON_CYC    (TON_CYC),
    .PERIOD_CYC (PERIOD_CYC)
  ) u_tick (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_o  (tick),
    .first_o ()
  );

  // north takes negative flux only, south positive only
  always @* begin
    om_mag = sms_abs(field_i);
    n_mag  = field_i[FW-1] ? sms_abs(field_i) : {FW{1'b0}};
    s_mag  = field_i[FW-1] ? {FW{1'b0}} : field_i;
  end

  sms_hyst_cmp #(.FW(FW), .OPERATE(OPERATE), .RELEASE(RELEASE)) u_om (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_i  (tick),
    .mag_i   (om_mag),
    .det_b_o (om_det_b)
  );

  sms_hyst_cmp #(.FW(FW), .OPERATE(OPERATE), .RELEASE(RELEASE)) u_n (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_i  (tick),
    .mag_i   (n_mag),
    .det_b_o (n_det_b)
  );

  sms_hyst_cmp #(.FW(FW), .OPERATE(OPERATE), .RELEASE(RELEASE)) u_s (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_i  (tick),
    .mag_i   (s_mag),
    .det_b_o (s_det_b)
  );

  // dual: near zero keeps both high
  // fixed by build, no runtime mode
  always @* begin
    if (DUAL) begin
      nxt_n_out = n_det_b;
      nxt_s_out = s_det_b;
    end else begin
      nxt_n_out = om_det_b;
      nxt_s_out = 1'b1;
    end
  end

  // update one cycle after each tick
  // push-pull drives from the first update on, open-drain enables only when low
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_d_ff          <= 1'b0;
      north_detect_out_o <= 1'b1;
      north_detect_oe_o  <= 1'b0;
      south_detect_out_o <= 1'b1;
      south_detect_oe_o  <= 1'b0;
      valid_o            <= 1'b0;
    end else begin
      tick_d_ff <= tick;
      if (tick_d_ff) begin
        valid_o            <= 1'b1;
        north_detect_out_o <= OPEN ? 1'b0 : nxt_n_out;
        north_detect_oe_o  <= OPEN ? ~nxt_n_out : 1'b1;
        south_detect_out_o <= nxt_s_out;
        south_detect_oe_o  <= DUAL;
      end
    end
  end

  // Awake flag covers the cycle in which the outputs change, so a pin never moves while asleep
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      awake_o <= 1'b1;
    end else if (tick_d_ff) begin
      awake_o <= 1'b1;
    end else if (valid_o) begin
      awake_o <= 1'b0;
    end
  end

endmodule // sms_switch

// >>> verif/sms_switch_asserts.sv
/* Port checker for sms_switch.
   Assumes one clock, active-low async reset, short bench counts. */
module sms_switch_chk #(
  parameter [1:0]   VARIANT    = 2'h3,
  parameter integer FW         = 16,
  parameter integer TON_CYC    = 5,
  parameter integer PERIOD_CYC = 20
) (
  // Clock, reset, pins
  input wire          clk_i,
  input wire          rst_b_i,
  input wire [FW-1:0] field_i,
  input wire          north_detect_out_o,
  input wire          north_detect_oe_o,
  input wire          south_detect_out_o,
  input wire          south_detect_oe_o,
  input wire          awake_o,
  input wire          valid_o
);
  localparam int TW = TON_CYC + 2;
  localparam int PW = PERIOD_CYC;
  wire signed [FW-1:0] fld = field_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_valid_in_time: assert property (!$past(rst_b_i) |-> ##[0:TW] valid_o)
    else $error("valid late");
  chk_none_before: assert property (!valid_o |-> !north_detect_oe_o && !south_detect_oe_o)
    else $error("driven before valid");
  chk_north_held: assert property ($changed(north_detect_out_o) |-> awake_o)
    else $error("north changed asleep");
  chk_south_held: assert property ($changed(south_detect_out_o) |-> awake_o)
    else $error("south changed asleep");
  chk_awake_pulse: assert property ($rose(awake_o) |=> !awake_o)
    else $error("awake too long");
  chk_wake_period: assert property ($rose(awake_o) |-> ##PW $rose(awake_o))
    else $error("wake period wrong");
  chk_pp_driven: assert property (valid_o && VARIANT != 2'h2 |-> north_detect_oe_o)
    else $error("push-pull not driven");
  chk_north_operate: assert property ($rose(awake_o) && $past(fld) < -3000 |-> !north_detect_out_o)
    else $error("north missed");
  chk_south_operate: assert property ($rose(awake_o) && $past(fld) > 3000 && VARIANT == 2'h3
    |-> !south_detect_out_o)
    else $error("south missed");
  cov_wake: cover property ($rose(awake_o));
  cov_north: cover property ($fell(north_detect_out_o));
  cov_south: cover property ($fell(south_detect_out_o));
endmodule // sms_switch_chk
bind sms_switch sms_switch_chk #(.VARIANT(VARIANT), .FW(FW), .TON_CYC(TON_CYC), .PERIOD_CYC(PERIOD_CYC))
  u_sms_switch_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .field_i(field_i),
  .north_detect_out_o(north_detect_out_o), .north_detect_oe_o(north_detect_oe_o),
  .south_detect_out_o(south_detect_out_o), .south_detect_oe_o(south_detect_oe_o),
  .awake_o(awake_o), .valid_o(valid_o));

// >>> verif/sms_host_gpio.sv
/* Host GPIO model reading two sensor pins.
   Assumes a pull-up on each node, so an undriven pin reads high. */
module sms_host_gpio (
  // Pin drivers
  input  wire [1:0] out_i,
  input  wire [1:0] oe_i,
  // Levels read
  output wire [1:0] pin_o,
  output wire       wired_o
);
  assign pin_o   = ~oe_i | out_i;
  // shared node is a wired AND
  assign wired_o = &pin_o;
endmodule // sms_host_gpio

// >>> verif/test_sms_switch.sv
/* Bench for the dual and open-drain omnipolar variants: table and random fields against a hysteresis model.
   Assumes the sample tick phase is fixed by the first valid update. */
module test_sms_switch;
  timeunit 1ns;
  timeprecision 1ns;
  localparam integer TON = 5;
  localparam integer PER = 20;
  reg         clk_i   = 1'b0;
  reg         rst_b_i = 1'b0;
  reg  [15:0] field_i = 16'h0000;
  wire        n_o, n_oe, s_o, s_oe, awk, vld, wired;
  wire [1:0]  pin;
  wire        od_o, od_oe, od_so, od_soe, od_awk, od_vld, od_wired;
  wire [1:0]  od_pin;
  integer     n_errors = 0, tests_run = 0, seed = 43571, nst, sst, ost, i, k;
  integer     tbl [0:9] = '{3000, 3001, 3001, 1500, 1499, -3000, -3001, -1500, -1499, 0};
  sms_switch #(.VARIANT(2'h3), .TON_CYC(TON), .PERIOD_CYC(PER)) u_sms_switch (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .field_i(field_i), .north_detect_out_o(n_o), .north_detect_oe_o(n_oe),
    .south_detect_out_o(s_o), .south_detect_oe_o(s_oe), .awake_o(awk), .valid_o(vld));
  sms_host_gpio u_sms_host_gpio (.out_i({s_o, n_o}), .oe_i({s_oe, n_oe}), .pin_o(pin), .wired_o(wired));
  // Open-drain omnipolar variant on the same field, read through its own pull-up
  sms_switch #(.VARIANT(2'h2), .TON_CYC(TON), .PERIOD_CYC(PER)) u_sms_switch_od (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .field_i(field_i), .north_detect_out_o(od_o), .north_detect_oe_o(od_oe),
    .south_detect_out_o(od_so), .south_detect_oe_o(od_soe), .awake_o(od_awk), .valid_o(od_vld));
  sms_host_gpio u_sms_host_gpio_od (.out_i({od_so, od_o}), .oe_i({od_soe, od_oe}), .pin_o(od_pin),
    .wired_o(od_wired));
  // Free-running clock
  initial forever #5 clk_i = ~clk_i;
  function integer xs(input integer s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task chk(input [47:0] nm, input exp, input got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("[ERR] %0s exp %b got %b", nm, exp, got);
    end
  endtask
  task complete_run;
    $display("tests_run %0d n_errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Reset, then wait a bounded time for the first update
  task start;
    field_i = 16'h0000;
    rst_b_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    nst = 0;
    sst = 0;
    ost = 0;
    for (k = 0; k < TON + 3 && vld !== 1'b1; k = k + 1) begin
      @(posedge clk_i);
      #1;
    end
    if (vld !== 1'b1) begin
      n_errors = n_errors + 1;
      complete_run;
    end
    chk("north0", 1'b1, n_o);
    chk("south0", 1'b1, s_o);
    chk("odpin0", 1'b1, od_pin[0]);
  endtask
  // One sampling period with a field held over the tick
  task step(input integer v);
    field_i = v[15:0];
    repeat (PER) @(posedge clk_i);
    #1;
    if (-v > 3000) nst = 1; else if (-v < 1500) nst = 0;
    if (v > 3000) sst = 1; else if (v < 1500) sst = 0;
    if (v > 3000 || -v > 3000) ost = 1; else if (v < 1500 && -v < 1500) ost = 0;
    chk("odpin", ost == 0, od_pin[0]);
    chk("odoe", ost == 1, od_oe);
    chk("odwired", ost == 0, od_wired);
    chk("north", nst == 0, n_o);
    chk("south", sst == 0, s_o);
    chk("pin", nst == 0, pin[0]);
    chk("wired", nst == 0 && sst == 0, wired);
    chk("awake", 1'b1, awk);
  endtask
  // Main sequence
  initial begin
    start;
    for (i = 0; i < 10; i = i + 1) step(tbl[i]);
    $display("test boundary done");
    for (i = 0; i < 40; i = i + 1) begin
      seed = xs(seed);
      step(seed % 8000);
    end
    $display("test random done");
    start;
    step(-4000);
    $display("test second reset done");
    complete_run;
  end
endmodule // test_sms_switch
